// ===== include/psls_pkg.sv
// Package for the port status light and suspend block
package psls_pkg;
    localparam int unsigned PSLS_PORTS        = 4;
    localparam int unsigned PSLS_PCLK_HZ      = 20_000_000;

    // Register byte offsets
    localparam logic [11:0] PSLS_OFF_CTRL1    = 12'h000;
    localparam logic [11:0] PSLS_OFF_CTRL2    = 12'h004;
    localparam logic [11:0] PSLS_OFF_BEHAV    = 12'h008;
    localparam logic [11:0] PSLS_OFF_BASIC    = 12'h00C;
    localparam logic [11:0] PSLS_OFF_STATUS   = 12'h010;
    localparam logic [11:0] PSLS_OFF_GLOBAL   = 12'h080;
    localparam logic [11:0] PSLS_PORT_STRIDE  = 12'h020;

    // Field positions
    localparam int unsigned PSLS_LEGACY_BIT   = 6;
    localparam int unsigned PSLS_CFG1_LSB     = 0;
    localparam int unsigned PSLS_CFG2_LSB     = 4;
    localparam int unsigned PSLS_RATE_LSB     = 0;
    localparam int unsigned PSLS_STRETCH_BIT  = 2;
    localparam int unsigned PSLS_ISO_BIT      = 10;
    localparam int unsigned PSLS_PDN_BIT      = 11;

    // Reset values
    localparam logic [31:0] PSLS_CTRL1_RST    = 32'h0000_0040;
    localparam logic [31:0] PSLS_CTRL2_RST    = 32'h0000_0010;
    localparam logic [31:0] PSLS_BEHAV_RST    = 32'h0000_0004;
    localparam logic [31:0] PSLS_BASIC_RST    = 32'h0000_0000;

    // Blink timing
    localparam int unsigned PSLS_BLINK_BASE_MS = 40;
    localparam int unsigned PSLS_BLINK_BASE_CYC = PSLS_PCLK_HZ / 1000 * PSLS_BLINK_BASE_MS;
    localparam int unsigned PSLS_STRETCH_MS   = 80;
    localparam int unsigned PSLS_STRETCH_CYC  = PSLS_PCLK_HZ / 1000 * PSLS_STRETCH_MS;

    // Link speed codes
    typedef enum logic [1:0] {
        PSLS_SPD_10   = 2'b00,
        PSLS_SPD_100  = 2'b01,
        PSLS_SPD_1000 = 2'b10,
        PSLS_SPD_NONE = 2'b11
    } psls_speed_e;

    // Light style
    typedef enum logic [1:0] {
        PSLS_STY_INDIV = 2'b00,
        PSLS_STY_TRI   = 2'b01,
        PSLS_STY_ENH   = 2'b10
    } psls_style_e;
endpackage

// ===== rtl/psls_blink.sv
// Shared blink phase generator with selectable rate
`timescale 1ns/1ps
module psls_blink #(
    parameter int unsigned BASE_CYC = 800_000
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Phase outputs, one per rate
    output logic [3:0]      phase
);
    logic [31:0] cnt_r;
    logic [3:0]  phase_r;
    logic [3:0]  div_r;
    wire         tick = (cnt_r == BASE_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= 32'h0000_0000;
            div_r   <= 4'h0;
            phase_r <= 4'h0;
        end else begin
            cnt_r <= tick ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
            if (tick) begin
                div_r   <= div_r + 4'h1;
                phase_r <= div_r + 4'h1;
            end
        end
    end

    // Rate n toggles at base * 2^n
    assign phase = phase_r;
endmodule

// ===== rtl/psls_stretch.sv
// Activity pulse stretcher for one port
`timescale 1ns/1ps
module psls_stretch #(
    parameter int unsigned STRETCH_CYC = 1_600_000
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic enable,
    input  wire logic pulse_in,
    // Stretched level
    output logic      level_out
);
    logic [31:0] cnt_r;
    logic        lvl_r;

    // Short bursts stay visible for a whole blink when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0000_0000;
            lvl_r <= 1'b0;
        end else if (pulse_in) begin
            cnt_r <= STRETCH_CYC;
            lvl_r <= 1'b1;
        end else if (enable && cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
            lvl_r <= 1'b1;
        end else begin
            cnt_r <= 32'h0000_0000;
            lvl_r <= 1'b0;
        end
    end

    assign level_out = lvl_r;
endmodule

// ===== rtl/psls_top.sv
// Port status lights and suspend gating, APB register slave
//
// Behaviour
// - Individual style: second light shows link, first blinks on activity.
// - Tri-color: gigabit second only, 100M first only, 10M both.
// - Tri-color 100M: second off, first on idle, blinking with traffic.
// - Tri-color 1000M: first off, second on idle, blinking with traffic.
// - Tri-color 10M: both on idle, both blink; no link both off.
// - Isolate, power-down or suspend force both port lights off.
// - Legacy select clear means enhanced style, per-light function codes.
// - Code 0: off no link, on link, blink with activity.
// - Codes 1-3: link/activity qualified to 1000, 100, 10 only.
// - Codes 4-6: link/activity qualified to 100/1000, 10/1000, 10/100.
// - Code 8: on full duplex, blink on half-duplex collision, else off.
// - Code 9 blinks on collision, 10 on activity, 12 shows fault.
// - Code 14 forces off, code 15 forces on.
// - Blink rate and pulse stretch come from per-port behaviour register.
// - Suspend high suppresses error, alarm and link change notifications.
// - Suspend disables PHY data, line and MAC paths, recovered clocks.
// - Suspend keeps interrupts and lights inactive.
// - Suspend leaves timing, serdes, PLL, management and chained clocks alone.
// - Legacy set: strap high individual style, strap low tri-color.
`timescale 1ns/1ps
module psls_top
    import psls_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Board pins
    input  wire logic                   suspend_pin,
    input  wire logic                   light_style_strap,
    // Per-port PHY status
    input  wire logic [2*psls_pkg::PSLS_PORTS-1:0] phy_speed,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_link,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_activity,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_full_duplex,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_collision,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_pd_fault,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_irq,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_link_change,
    // Lights
    output logic [psls_pkg::PSLS_PORTS-1:0]        port_light_first,
    output logic [psls_pkg::PSLS_PORTS-1:0]        port_light_second,
    // Suspend gating to PHY and system
    output logic [psls_pkg::PSLS_PORTS-1:0]        phy_enable,
    output logic [psls_pkg::PSLS_PORTS-1:0]        phy_data_enable,
    output logic [psls_pkg::PSLS_PORTS-1:0]        rcvd_clk_enable,
    output logic                                   chain_clk_enable,
    output logic                                   irq_out,
    output logic [psls_pkg::PSLS_PORTS-1:0]        link_change_out
);
    localparam int N = PSLS_PORTS;

    // Pin synchronisers
    logic       susp_s1_r;
    logic       susp_s2_r;
    logic       strap_s1_r;
    logic       strap_s2_r;
    logic       strap_lat_r;
    logic       strap_done_r;
    logic [1:0] strap_arm_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_s1_r  <= 1'b1;
            susp_s2_r  <= 1'b1;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else begin
            susp_s1_r  <= suspend_pin;
            susp_s2_r  <= susp_s1_r;
            strap_s1_r <= light_style_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Strap caught on the third edge, once the synchroniser holds the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_lat_r  <= 1'b0;
            strap_done_r <= 1'b0;
            strap_arm_r  <= 2'b00;
        end else begin
            strap_arm_r <= {strap_arm_r[0], 1'b1};
            if (strap_arm_r[1] && !strap_done_r) begin
                strap_lat_r  <= strap_s2_r;
                strap_done_r <= 1'b1;
            end
        end
    end

    wire suspend = susp_s2_r;

    // Registers
    logic [31:0] ctrl1_r [N];
    logic [31:0] ctrl2_r [N];
    logic [31:0] behav_r [N];
    logic [31:0] basic_r [N];
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    wire        apb_setup  = psel && !penable;
    wire        apb_access = psel && penable && pready_r;
    wire [1:0]  a_port     = paddr[6:5];
    wire [4:0]  a_reg      = paddr[4:0];
    wire        a_in_port  = (paddr < PSLS_OFF_GLOBAL) && (paddr[1:0] == 2'b00);
    wire        a_is_glob  = (paddr == PSLS_OFF_GLOBAL);
    wire        a_rw_reg   = a_in_port && (a_reg == PSLS_OFF_CTRL1[4:0] ||
                             a_reg == PSLS_OFF_CTRL2[4:0] || a_reg == PSLS_OFF_BEHAV[4:0] ||
                             a_reg == PSLS_OFF_BASIC[4:0]);
    wire        a_ro_reg   = (a_in_port && a_reg == PSLS_OFF_STATUS[4:0]) || a_is_glob;
    wire        a_ok       = a_rw_reg || (a_ro_reg && !pwrite);

    // Per-port status word
    function automatic logic [31:0] status_word(input int p);
        status_word = {24'h00_0000, port_light_second[p], port_light_first[p],
                       phy_pd_fault[p], phy_full_duplex[p], phy_link[p],
                       1'b0, phy_speed[2*p +: 2]};
    endfunction

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a_is_glob) begin
            rd_mux = {30'h0000_0000, strap_lat_r, suspend};
        end else if (a_in_port) begin
            case (a_reg)
                PSLS_OFF_CTRL1[4:0]:  rd_mux = ctrl1_r[a_port];
                PSLS_OFF_CTRL2[4:0]:  rd_mux = ctrl2_r[a_port];
                PSLS_OFF_BEHAV[4:0]:  rd_mux = behav_r[a_port];
                PSLS_OFF_BASIC[4:0]:  rd_mux = basic_r[a_port];
                PSLS_OFF_STATUS[4:0]: rd_mux = status_word(int'(a_port));
                default:              rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup && !a_ok;
            if (apb_setup && !pwrite) begin
                prdata_r <= a_ok ? rd_mux : 32'h0000_0000;
            end
        end
    end

    wire wr_en = apb_access && pwrite && a_rw_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < N; p++) begin
                ctrl1_r[p] <= PSLS_CTRL1_RST;
                ctrl2_r[p] <= PSLS_CTRL2_RST;
                behav_r[p] <= PSLS_BEHAV_RST;
                basic_r[p] <= PSLS_BASIC_RST;
            end
        end else if (wr_en) begin
            case (a_reg)
                PSLS_OFF_CTRL1[4:0]: ctrl1_r[a_port] <= pwdata;
                PSLS_OFF_CTRL2[4:0]: ctrl2_r[a_port] <= pwdata;
                PSLS_OFF_BEHAV[4:0]: behav_r[a_port] <= pwdata;
                PSLS_OFF_BASIC[4:0]: basic_r[a_port] <= pwdata;
                default:             ctrl1_r[a_port] <= ctrl1_r[a_port];
            endcase
        end
    end

    // Blink phases
    logic [3:0] phase;
    psls_blink #(.BASE_CYC(PSLS_BLINK_BASE_CYC)) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (phase)
    );

    // Enhanced function decode for one light
    function automatic logic enh_light(
        input logic [3:0] code,
        input logic [1:0] spd,
        input logic       lnk,
        input logic       act,
        input logic       fdx,
        input logic       col,
        input logic       flt,
        input logic       blk
    );
        logic s10;
        logic s100;
        logic s1g;
        s10  = lnk && spd == PSLS_SPD_10;
        s100 = lnk && spd == PSLS_SPD_100;
        s1g  = lnk && spd == PSLS_SPD_1000;
        case (code)
            4'h0:    enh_light = lnk && (!act || blk);
            4'h1:    enh_light = s1g && (!act || blk);
            4'h2:    enh_light = s100 && (!act || blk);
            4'h3:    enh_light = s10 && (!act || blk);
            4'h4:    enh_light = (s100 || s1g) && (!act || blk);
            4'h5:    enh_light = (s10 || s1g) && (!act || blk);
            4'h6:    enh_light = (s10 || s100) && (!act || blk);
            4'h8:    enh_light = lnk && (fdx || (col && blk));
            4'h9:    enh_light = col && blk;
            4'hA:    enh_light = act && blk;
            4'hC:    enh_light = flt;
            4'hE:    enh_light = 1'b0;
            4'hF:    enh_light = 1'b1;
            default: enh_light = 1'b0;
        endcase
    endfunction

    logic [N-1:0] act_str;
    logic [N-1:0] first_nxt;
    logic [N-1:0] second_nxt;

    for (genvar g = 0; g < N; g++) begin : g_port
        // Stretch enable and rate per port
        psls_stretch #(.STRETCH_CYC(PSLS_STRETCH_CYC)) u_str (
            .pclk      (pclk),
            .presetn   (presetn),
            .enable    (behav_r[g][PSLS_STRETCH_BIT]),
            .pulse_in  (phy_activity[g]),
            .level_out (act_str[g])
        );

        wire [1:0] rate   = behav_r[g][PSLS_RATE_LSB +: 2];
        wire       blk    = phase[rate];
        wire [1:0] spd    = phy_speed[2*g +: 2];
        wire       lnk    = phy_link[g] && spd != PSLS_SPD_NONE;
        wire       act    = act_str[g];
        wire       col    = phy_collision[g] && !phy_full_duplex[g];
        wire       on_act = !act || blk;
        wire       legacy = ctrl1_r[g][PSLS_LEGACY_BIT];
        wire       off    = basic_r[g][PSLS_ISO_BIT] || basic_r[g][PSLS_PDN_BIT] ||
                            suspend;
        psls_style_e style;
        assign style = !legacy ? PSLS_STY_ENH :
                       strap_lat_r ? PSLS_STY_INDIV : PSLS_STY_TRI;

        logic f_raw;
        logic s_raw;
        always_comb begin
            f_raw = 1'b0;
            s_raw = 1'b0;
            case (style)
                PSLS_STY_INDIV: begin
                    s_raw = lnk;
                    f_raw = lnk && act && blk;
                end
                PSLS_STY_TRI: begin
                    f_raw = lnk && (spd == PSLS_SPD_100 || spd == PSLS_SPD_10) && on_act;
                    s_raw = lnk && (spd == PSLS_SPD_1000 || spd == PSLS_SPD_10) && on_act;
                end
                PSLS_STY_ENH: begin
                    f_raw = enh_light(ctrl2_r[g][PSLS_CFG1_LSB +: 4], spd, lnk, act,
                                      phy_full_duplex[g], col, phy_pd_fault[g], blk);
                    s_raw = enh_light(ctrl2_r[g][PSLS_CFG2_LSB +: 4], spd, lnk, act,
                                      phy_full_duplex[g], col, phy_pd_fault[g], blk);
                end
                default: begin
                    f_raw = 1'b0;
                    s_raw = 1'b0;
                end
            endcase
        end

        assign first_nxt[g]  = f_raw && !off;
        assign second_nxt[g] = s_raw && !off;
    end

    // Output flops
    logic [N-1:0] first_r;
    logic [N-1:0] second_r;
    logic [N-1:0] phy_en_r;
    logic [N-1:0] rclk_en_r;
    logic [N-1:0] lchg_r;
    logic         chain_r;
    logic         irq_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r   <= '0;
            second_r  <= '0;
            phy_en_r  <= '0;
            rclk_en_r <= '0;
            lchg_r    <= '0;
            chain_r   <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            first_r   <= first_nxt;
            second_r  <= second_nxt;
            phy_en_r  <= {N{!suspend}};
            rclk_en_r <= {N{!suspend}};
            lchg_r    <= suspend ? '0 : phy_link_change;
            irq_r     <= !suspend && (|phy_irq);
            chain_r   <= 1'b1;
        end
    end

    // Config register access stays open in suspend; data paths, recovered clocks, interrupts, link change and lights close
    assign port_light_first  = first_r;
    assign port_light_second = second_r;
    assign phy_enable        = phy_en_r;
    assign phy_data_enable   = phy_en_r;
    assign rcvd_clk_enable   = rclk_en_r;
    assign chain_clk_enable  = chain_r;
    assign irq_out           = irq_r;
    assign link_change_out   = lchg_r;
    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
endmodule

// ===== testbench/psls_top_props.sv
// Checker for the port status light and suspend block
`timescale 1ns/1ps
module psls_top_props
    import psls_pkg::*;
(
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // APB
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pready,
    // Board and PHY
    input  wire logic                              suspend_pin,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_irq,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_link_change,
    // Outputs watched
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   port_light_first,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   port_light_second,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_enable,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   phy_data_enable,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   rcvd_clk_enable,
    input  wire logic                              chain_clk_enable,
    input  wire logic                              irq_out,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   link_change_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Four edges cover the two-flop sync plus the output register
    sequence held_susp;
        suspend_pin [*4];
    endsequence
    sequence held_run;
        !suspend_pin [*4];
    endsequence

    susp_lights_a:
        assert property (held_susp |-> (port_light_first | port_light_second) == '0)
        else $error("light lit while suspended");
    susp_irq_a:
        assert property (held_susp |-> !irq_out) else $error("interrupt while suspended");
    susp_notify_a:
        assert property (held_susp |-> link_change_out == '0)
        else $error("link change passed while suspended");
    susp_phy_a:
        assert property (held_susp |-> (phy_enable | phy_data_enable | rcvd_clk_enable) == '0)
        else $error("phy path enabled while suspended");
    chain_susp_a:
        assert property (held_susp |-> chain_clk_enable) else $error("chained clock stopped");
    chain_run_a:
        assert property (presetn [*3] |-> chain_clk_enable) else $error("chained clock low");
    irq_follow_a:
        assert property (held_run |=> irq_out == (|$past(phy_irq)))
        else $error("interrupt does not follow phy");
    notify_follow_a:
        assert property (held_run |=> link_change_out == $past(phy_link_change))
        else $error("link change does not follow phy");
    apb_answer_a:
        assert property (psel && !penable |=> pready) else $error("no answer after setup");
endmodule

bind psls_top psls_top_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .suspend_pin(suspend_pin), .phy_irq(phy_irq), .phy_link_change(phy_link_change),
    .port_light_first(port_light_first), .port_light_second(port_light_second),
    .phy_enable(phy_enable), .phy_data_enable(phy_data_enable),
    .rcvd_clk_enable(rcvd_clk_enable), .chain_clk_enable(chain_clk_enable),
    .irq_out(irq_out), .link_change_out(link_change_out)
);

// ===== testbench/psls_board.sv
// Board model: suspend control line and indicator lights
`timescale 1ns/1ps
module psls_board
    import psls_pkg::*;
(
    // Clock and bench control
    input  wire logic                              pclk,
    input  wire logic                              hold_req,
    // Board pins
    output logic                                   suspend_pin,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   port_light_first,
    input  wire logic [psls_pkg::PSLS_PORTS-1:0]   port_light_second,
    // Lights seen lit
    output logic [psls_pkg::PSLS_PORTS-1:0]        lit
);
    // Held suspended from power-up, dropped once init is done
    initial suspend_pin = 1'b1;
    always @(posedge pclk) suspend_pin <= hold_req;
    assign lit = port_light_first | port_light_second;
endmodule

// ===== testbench/psls_top_bench.sv
// Self-checking bench for the port status light and suspend block
`timescale 1ns/1ps
module psls_top_bench;
    import psls_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, suspend_pin, cce, irqo, e;
    logic        hold_req = 1'b1;
    logic        strap = 1'b1;
    logic [7:0]  spd = 8'hFF;
    logic [3:0]  lnk = 4'h0, act = 4'h0, fdx = 4'h0, col = 4'h0, flt = 4'h0;
    logic [3:0]  irq = 4'h0, lchg = 4'h0;
    logic [3:0]  lf, ls, pen, pden, rce, lco, lit;
    logic [31:0] q;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    psls_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .suspend_pin(suspend_pin), .light_style_strap(strap),
        .phy_speed(spd), .phy_link(lnk), .phy_activity(act), .phy_full_duplex(fdx),
        .phy_collision(col), .phy_pd_fault(flt), .phy_irq(irq), .phy_link_change(lchg),
        .port_light_first(lf), .port_light_second(ls), .phy_enable(pen),
        .phy_data_enable(pden), .rcvd_clk_enable(rce), .chain_clk_enable(cce),
        .irq_out(irqo), .link_change_out(lco));
    psls_board u_board (.pclk(pclk), .hold_req(hold_req), .suspend_pin(suspend_pin),
        .port_light_first(lf), .port_light_second(ls), .lit(lit));

    always #25 pclk = ~pclk;

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard, well above the under a thousand cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt;
        repeat (5) @(posedge pclk);
    endtask

    task automatic phy(input logic [1:0] s, input logic a, input logic f, input logic d);
        spd <= {4{s}};
        lnk <= {4{s != 2'b11}};
        act <= {4{a}};
        fdx <= {4{f}};
        flt <= {4{d}};
        wt();
    endtask

    task automatic rst(input logic st);
        presetn <= 1'b0;
        hold_req <= 1'b1;
        strap <= st;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        hold_req <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // Stretch off, so idle states show at once after traffic stops
    task automatic nostretch;
        for (int p = 0; p < 4; p++) apb(1'b1, 12'(p * 32 + 8), 32'h0000_0000);
    endtask

    function automatic logic enh(input logic [3:0] c, input logic [1:0] s, input logic k);
        case (c)
            4'd0: return s != 2'b11;
            4'd1: return s == 2'b10;
            4'd2: return s == 2'b01;
            4'd3: return s == 2'b00;
            4'd4: return s == 2'b01 || s == 2'b10;
            4'd5: return s == 2'b00 || s == 2'b10;
            4'd6: return s == 2'b00 || s == 2'b01;
            4'd8: return k && s != 2'b11;
            4'd12: return k;
            4'd15: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic t_regs;
        apb(1'b0, PSLS_OFF_CTRL1, 32'h0000_0000);
        chk(q, PSLS_CTRL1_RST);
        apb(1'b0, PSLS_OFF_CTRL2, 32'h0000_0000);
        chk(q, PSLS_CTRL2_RST);
        apb(1'b0, PSLS_OFF_BEHAV, 32'h0000_0000);
        chk(q, PSLS_BEHAV_RST);
        apb(1'b0, PSLS_OFF_BASIC, 32'h0000_0000);
        chk(q, PSLS_BASIC_RST);
        apb(1'b1, PSLS_OFF_BEHAV, 32'h0000_0003);
        apb(1'b0, PSLS_OFF_BEHAV, 32'h0000_0000);
        chk(q, 32'h0000_0003);
        apb(1'b0, 12'hFF0, 32'h0000_0000);
        chk({q[30:0], e}, 32'h0000_0001);
        apb(1'b0, PSLS_OFF_GLOBAL, 32'h0000_0000);
        chk(q & 32'h0000_0003, 32'h0000_0002);
        nostretch();
        $display("register test done");
    endtask

    task automatic t_indiv;
        phy(2'b11, 1'b0, 1'b0, 1'b0);
        chk({ls, lf}, 8'h00);
        for (int s = 0; s < 3; s++) begin
            phy(2'(s), 1'b0, 1'b0, 1'b0);
            chk({ls, lf}, 8'hF0);
        end
        phy(2'b10, 1'b1, 1'b0, 1'b0);
        chk(ls, 4'hF);
        $display("individual style test done");
    endtask

    task automatic t_tri;
        apb(1'b0, PSLS_OFF_GLOBAL, 32'h0000_0000);
        chk(q & 32'h0000_0003, 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            phy(2'(s), 1'b0, 1'b0, 1'b0);
            chk({ls, lf}, {{4{s == 0 || s == 2}}, {4{s < 2}}});
        end
        phy(2'b01, 1'b1, 1'b0, 1'b0);
        chk(ls, 4'h0);
        phy(2'b10, 1'b1, 1'b0, 1'b0);
        chk(lf, 4'h0);
        $display("tri-color test done");
    endtask

    task automatic t_enh;
        apb(1'b1, PSLS_OFF_CTRL1, 32'h0000_0000);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, PSLS_OFF_CTRL2, {24'h00_0000, 4'(15 - c), 4'(c)});
            for (int k = 0; k < 8; k++) begin
                phy(2'(k), 1'b0, k[2], k[2]);
                chk(lf[0], enh(4'(c), 2'(k), k[2]));
                chk(ls[0], enh(4'(15 - c), 2'(k), k[2]));
            end
        end
        $display("enhanced function test done");
    endtask

    task automatic t_force;
        apb(1'b1, PSLS_OFF_CTRL2, 32'h0000_00FF);
        phy(2'b10, 1'b0, 1'b1, 1'b0);
        chk({ls[0], lf[0]}, 2'b11);
        apb(1'b1, PSLS_OFF_BASIC, 32'(1) << PSLS_ISO_BIT);
        wt();
        chk({ls[0], lf[0]}, 2'b00);
        apb(1'b1, PSLS_OFF_BASIC, 32'(1) << PSLS_PDN_BIT);
        wt();
        chk({ls[0], lf[0]}, 2'b00);
        apb(1'b1, PSLS_OFF_BASIC, 32'h0000_0000);
        wt();
        chk({ls[0], lf[0]}, 2'b11);
        $display("force-off test done");
    endtask

    task automatic t_susp;
        irq <= 4'h5;
        lchg <= 4'hA;
        wt();
        chk({irqo, lco}, 5'h1A);
        hold_req <= 1'b1;
        wt();
        chk(lit, 4'h0);
        chk({irqo, lco}, 5'h00);
        chk({pen, pden, rce, cce}, 13'h0001);
        apb(1'b0, PSLS_OFF_CTRL2, 32'h0000_0000);
        chk(q, 32'h0000_00FF);
        hold_req <= 1'b0;
        wt();
        chk({irqo, lco, lf[0]}, 6'h35);
        $display("suspend test done");
    endtask

    initial begin
        rst(1'b1);
        t_regs();
        t_indiv();
        rst(1'b0);
        nostretch();
        t_tri();
        t_enh();
        t_force();
        t_susp();
        results();
    end
endmodule
